// File: logic/i2c_slave_cfg_pkg.sv
// Package: register offsets, field positions, reset values and modes of the two-wire slave block.
package i2c_slave_cfg_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [2:0] off_control_zero = 3'h0;
    localparam logic [2:0] off_status_flags = 3'h1;
    localparam logic [2:0] off_data_buffer = 3'h2;
    localparam logic [2:0] off_own_address = 3'h3;
    localparam logic [2:0] off_timeout_control = 3'h4;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] rst_control_zero = 8'he0;
    localparam logic [7:0] rst_status_flags = 8'h81;
    localparam logic [7:0] rst_data_buffer = 8'h00;
    localparam logic [7:0] rst_own_address = 8'h00;
    localparam logic [7:0] rst_timeout_control = 8'h00;
    // ****************************************
    // Field positions in module_control_zero
    // ****************************************
    localparam int pos_mode_lo = 5;
    localparam int pos_async = 4;
    localparam int pos_deb_lo = 2;
    localparam int pos_enable = 1;
    localparam int pos_incomplete = 0;
    // Field positions in bus_status_flags.
    localparam int pos_done = 7;
    localparam int pos_match = 6;
    localparam int pos_busy = 5;
    localparam int pos_transmit = 4;
    localparam int pos_txack = 3;
    localparam int pos_rw = 2;
    localparam int pos_wake = 1;
    localparam int pos_rxack = 0;
    localparam logic [2:0] mode_two_wire_slave = 3'h6;
    // Debounce lengths in system clocks.
    localparam logic [2:0] deb_cycles_short = 3'h2;
    localparam logic [2:0] deb_cycles_long = 3'h4;
    // ****************************************
    // Bus state machine
    // ****************************************
    typedef enum logic [5:0] {
        st_idle = 6'h01,
        st_addr = 6'h02,
        st_ack = 6'h04,
        st_tx = 6'h08,
        st_rx = 6'h10,
        st_mack = 6'h20
    } bus_state_t;
endpackage

// File: logic/i2c_slave_cfg.sv
// Two-wire slave interface: configuration registers, clock debounce and byte engine.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_cfg
    import i2c_slave_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [1:0] pullup_ctrl,
    output logic [1:0] pullup_en,
    output logic module_irq,
    output logic [2:0] active_function
);
    import i2c_slave_cfg_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [2:0] deb_len(input logic [1:0] sel);
        if (sel[1]) begin
            return deb_cycles_long;
        end else if (sel[0]) begin
            return deb_cycles_short;
        end
        return 3'h0;
    endfunction

    // ****************************************
    // State declarations
    // ****************************************
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] stat_q, stat_d;
    logic [7:0] data_q, data_d;
    logic [7:0] addr_q, addr_d;
    logic [7:0] tmo_q, tmo_d;
    logic [7:0] rdata_q, rdata_d;
    logic scl_f_q, scl_f_d;
    logic [2:0] deb_cnt_q, deb_cnt_d;
    logic scl_prev_q, scl_prev_d;
    logic sda_prev_q, sda_prev_d;
    bus_state_t st_q, st_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] bit_q, bit_d;
    logic sda_drv_q, sda_drv_d;
    logic irq_q, irq_d;

    logic two_wire;
    logic enabled;
    logic [1:0] deb_sel;
    logic scl_rise, scl_fall, start_c, stop_c;

    // Two-wire mode needs async select clear and mode 110.
    assign two_wire = !ctrl_q[pos_async] && ctrl_q[7:pos_mode_lo] == mode_two_wire_slave;
    assign enabled = two_wire && ctrl_q[pos_enable];
    assign deb_sel = two_wire ? ctrl_q[3:pos_deb_lo] : 2'h0;

    // ****************************************
    // Clock debounce
    // ****************************************
    // Raw inputs are taken as synchronous; the filter only rejects short glitches.
    always_comb begin
        scl_f_d = scl_f_q;
        deb_cnt_d = 3'h0;
        if (deb_sel == 2'h0) begin
            scl_f_d = scl_in;
        end else if (scl_in != scl_f_q) begin
            deb_cnt_d = deb_cnt_q + 3'h1;
            if (deb_cnt_d >= deb_len(deb_sel)) begin
                scl_f_d = scl_in;
                deb_cnt_d = 3'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_f_q <= 1'b1;
            deb_cnt_q <= 3'h0;
        end else begin
            scl_f_q <= scl_f_d;
            deb_cnt_q <= deb_cnt_d;
        end
    end

    assign scl_rise = scl_f_q && !scl_prev_q;
    assign scl_fall = !scl_f_q && scl_prev_q;
    assign start_c = scl_f_q && scl_prev_q && sda_prev_q && !sda_in;
    assign stop_c = scl_f_q && scl_prev_q && !sda_prev_q && sda_in;

    // ****************************************
    // Bus engine and registers
    // ****************************************
    always_comb begin
        ctrl_d = ctrl_q;
        stat_d = stat_q;
        data_d = data_q;
        addr_d = addr_q;
        tmo_d = tmo_q;
        rdata_d = 8'h00;
        scl_prev_d = scl_f_q;
        sda_prev_d = sda_in;
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        sda_drv_d = sda_drv_q;
        irq_d = 1'b0;

        // Software access first, so that bus events later in this block win over it.
        if (reg_wr) begin
            case (reg_addr)
                off_control_zero: begin
                    ctrl_d = reg_wdata;
                end
                off_status_flags: begin
                    if (two_wire) begin
                        stat_d[pos_transmit] = reg_wdata[pos_transmit];
                        stat_d[pos_txack] = reg_wdata[pos_txack];
                        stat_d[pos_wake] = reg_wdata[pos_wake];
                    end
                end
                off_data_buffer: begin
                    data_d = reg_wdata;
                end
                off_own_address: begin
                    addr_d = reg_wdata;
                end
                off_timeout_control: begin
                    if (two_wire) begin
                        tmo_d = reg_wdata;
                    end
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                off_control_zero: rdata_d = ctrl_q;
                off_status_flags: rdata_d = two_wire ? stat_q : 8'h00;
                off_data_buffer: rdata_d = data_q;
                off_own_address: rdata_d = addr_q;
                off_timeout_control: rdata_d = two_wire ? tmo_q : 8'h00;
                default: rdata_d = 8'h00;
            endcase
        end

        if (!enabled) begin
            // Bus flags (done, match, busy, rw, rxack) return to defaults so the next enable starts clean.
            st_d = st_idle;
            sda_drv_d = 1'b0;
            stat_d[pos_done] = 1'b1;
            stat_d[pos_match] = 1'b0;
            stat_d[pos_busy] = 1'b0;
            stat_d[pos_rw] = 1'b0;
            stat_d[pos_rxack] = 1'b1;
        end else if (start_c) begin
            stat_d[pos_busy] = 1'b1;
            stat_d[pos_match] = 1'b0;
            st_d = st_addr;
            bit_d = 4'h0;
            sda_drv_d = 1'b0;
        end else if (stop_c) begin
            stat_d[pos_busy] = 1'b0;
            st_d = st_idle;
            sda_drv_d = 1'b0;
        end else begin
            case (st_q)
                st_idle: begin
                end
                st_addr: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_in};
                        bit_d = bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'h8) begin
                        if (sh_q[7:1] == addr_q[7:1]) begin
                            stat_d[pos_match] = 1'b1;
                            stat_d[pos_rw] = sh_q[0];
                            irq_d = 1'b1;
                            sda_drv_d = 1'b1;
                            st_d = st_ack;
                        end else begin
                            st_d = st_idle;
                        end
                    end
                end
                st_ack: begin
                    if (scl_fall) begin
                        bit_d = 4'h0;
                        stat_d[pos_done] = 1'b0;
                        if (stat_q[pos_rw]) begin
                            sh_d = data_q;
                            sda_drv_d = !data_q[7];
                            st_d = st_tx;
                        end else begin
                            sda_drv_d = 1'b0;
                            st_d = st_rx;
                        end
                    end
                end
                st_rx: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_in};
                        bit_d = bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'h8) begin
                        data_d = sh_q;
                        stat_d[pos_done] = 1'b1;
                        irq_d = 1'b1;
                        sda_drv_d = !stat_q[pos_txack];
                        st_d = st_ack;
                        stat_d[pos_rw] = 1'b0;
                    end
                end
                st_tx: begin
                    if (scl_fall) begin
                        bit_d = bit_q + 4'h1;
                        sh_d = {sh_q[6:0], 1'b1};
                        if (bit_q == 4'h7) begin
                            sda_drv_d = 1'b0;
                            st_d = st_mack;
                        end else begin
                            sda_drv_d = !sh_q[6];
                        end
                    end
                end
                st_mack: begin
                    if (scl_rise) begin
                        stat_d[pos_rxack] = sda_in;
                        stat_d[pos_done] = 1'b1;
                        irq_d = 1'b1;
                    end
                    if (scl_fall) begin
                        bit_d = 4'h0;
                        stat_d[pos_done] = 1'b0;
                        // A missing acknowledge leaves the line free for the stop.
                        if (stat_q[pos_rxack]) begin
                            st_d = st_idle;
                        end else begin
                            sh_d = data_q;
                            sda_drv_d = !data_q[7];
                            st_d = st_tx;
                        end
                    end
                end
                default: begin
                    st_d = st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_q <= rst_control_zero;
            stat_q <= rst_status_flags;
            data_q <= rst_data_buffer;
            addr_q <= rst_own_address;
            tmo_q <= rst_timeout_control;
            rdata_q <= 8'h00;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            st_q <= st_idle;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            sda_drv_q <= 1'b0;
            irq_q <= 1'b0;
            pullup_en <= 2'h0;
            active_function <= 3'h0;
        end else begin
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            data_q <= data_d;
            addr_q <= addr_d;
            tmo_q <= tmo_d;
            rdata_q <= rdata_d;
            scl_prev_q <= scl_prev_d;
            sda_prev_q <= sda_prev_d;
            st_q <= st_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            sda_drv_q <= sda_drv_d;
            irq_q <= irq_d;
            pullup_en <= pullup_ctrl;
            // Function code: 0 off, 1 UART, 2 three-wire, 3 two-wire, 4 undefined mode.
            if (!ctrl_d[pos_enable]) begin
                active_function <= 3'h0;
            end else if (ctrl_d[pos_async]) begin
                active_function <= 3'h1;
            end else if (ctrl_d[7:pos_mode_lo] == mode_two_wire_slave) begin
                active_function <= 3'h3;
            end else if (ctrl_d[7:pos_mode_lo] == 3'h7) begin
                active_function <= 3'h4;
            end else begin
                active_function <= 3'h2;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Output value is always low; only the enable moves, so the line is never driven high.
    assign reg_rdata = rdata_q;
    assign sda_out = 1'b0;
    assign sda_oe_n = !sda_drv_q;
    assign scl_out = 1'b0;
    assign scl_oe_n = 1'b1;
    assign module_irq = irq_q;
endmodule
`default_nettype wire

// File: test/i2c_slave_cfg_asserts.sv
// Concurrent checks on the ports of the two-wire slave block.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_cfg_asserts
    import i2c_slave_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [1:0] pullup_ctrl,
    input wire logic [1:0] pullup_en,
    input wire logic module_irq,
    input wire logic [2:0] active_function
);
    default clocking dclk @(posedge clk);
    endclocking
    default disable iff (!rstn);
    chk_scl_released: assert property (scl_oe_n)
        else $error("Slave drove the clock line.");
    chk_sda_only_low: assert property (!sda_oe_n |-> !sda_out)
        else $error("Data line driven high.");
    chk_sda_scl_low: assert property (!$stable(sda_oe_n) |-> !scl_in)
        else $error("Data drive changed while clock high.");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data not zero outside a read.");
    chk_two_wire_on: assert property (reg_wr && reg_addr == off_control_zero && reg_wdata[pos_enable] &&
        reg_wdata[7:5] == mode_two_wire_slave && !reg_wdata[pos_async] |-> ##[1:2] active_function == 3'h3)
        else $error("Two-wire function not selected.");
    chk_uart_wins: assert property (reg_wr && reg_addr == off_control_zero && reg_wdata[pos_enable] &&
        reg_wdata[pos_async] |-> ##[1:2] active_function == 3'h1)
        else $error("Async select did not win.");
    chk_disable_idle: assert property (reg_wr && reg_addr == off_control_zero &&
        !reg_wdata[pos_enable] |-> ##[1:2] active_function == 3'h0)
        else $error("Disabled module still active.");
    chk_off_no_drive: assert property ((active_function != 3'h3)[*3] |-> sda_oe_n)
        else $error("Data line driven outside two-wire mode.");
    chk_irq_pulse: assert property (module_irq |=> !module_irq)
        else $error("Request longer than one cycle.");
    chk_pullup_follow: assert property ($changed(pullup_ctrl) |=> pullup_en == $past(pullup_ctrl))
        else $error("Pull-up enable did not follow.");
    cov_irq: cover property (module_irq);
    cov_ack_drive: cover property ($fell(sda_oe_n));
    cov_two_wire: cover property (active_function == 3'h3);
endmodule
bind i2c_slave_cfg i2c_slave_cfg_asserts u_chk (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pullup_ctrl(pullup_ctrl), .pullup_en(pullup_en),
    .module_irq(module_irq), .active_function(active_function)
);
`default_nettype wire

// File: test/i2c_master_model.sv
// Behavioural two-wire bus master on the far side of the slave.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl_pull,
    output logic sda_pull
);
    // Half a bus phase in system clocks; long enough for any debounce setting.
    int half = 12;
    int glitch = 0;
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Data only moves a half phase after the clock falls, so the filtered clock never sees a false stop.
    task automatic bit_out(input logic b);
        sda_pull <= ~b;
        w(half);
        if (glitch > 0) begin
            scl_pull <= 1'b0;
            w(glitch);
            scl_pull <= 1'b1;
            glitch = 0;
            w(half);
        end
        scl_pull <= 1'b0;
        w(half);
        scl_pull <= 1'b1;
        w(half);
    endtask
    task automatic bit_in(output logic b);
        sda_pull <= 1'b0;
        w(half);
        scl_pull <= 1'b0;
        w(half);
        b = sda_line;
        scl_pull <= 1'b1;
        w(half);
    endtask
    task automatic start();
        w(half);
        sda_pull <= 1'b1;
        w(half);
        scl_pull <= 1'b1;
        w(half);
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        w(half);
        scl_pull <= 1'b0;
        w(half);
        sda_pull <= 1'b0;
        w(half);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(ack);
    endtask
    task automatic recv(output logic [7:0] d, input logic nack);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(nack);
    endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the two-wire slave configuration block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import i2c_slave_cfg_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] pullup_ctrl = 2'h0;
    logic [7:0] reg_rdata;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, module_irq, scl_pull, sda_pull;
    logic [1:0] pullup_en;
    logic [2:0] active_function;
    // ****************************************
    // Bus wires with pull-ups
    // ****************************************
    wire logic scl_line = !scl_pull && (scl_oe_n || scl_out);
    wire logic sda_line = !sda_pull && (sda_oe_n || sda_out);
    int error_cnt = 0;
    int num_checks = 0;
    // Counts request pulses so that the bench can see each one the slave raises.
    int irq_cnt = 0;
    always @(posedge clk) begin
        if (module_irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
    end
    i2c_slave_cfg u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pullup_ctrl(pullup_ctrl),
        .pullup_en(pullup_en), .module_irq(module_irq), .active_function(active_function));
    i2c_master_model m (.clk(clk), .sda_line(sda_line), .scl_pull(scl_pull), .sda_pull(sda_pull));
    initial begin
        forever #2 clk = ~clk;
    end
    function automatic logic two_wire(input logic [7:0] c);
        return c[7:5] == mode_two_wire_slave && !c[pos_async];
    endfunction
    function automatic logic [2:0] exp_func(input logic [7:0] c);
        if (!c[pos_enable]) return 3'h0;
        if (c[pos_async]) return 3'h1;
        if (two_wire(c)) return 3'h3;
        return (c[7:5] == 3'h7) ? 3'h4 : 3'h2;
    endfunction
    task automatic final_report();
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        pullup_ctrl <= 2'($urandom);
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask = 8'hff);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata & mask, exp);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        final_report();
    end
    initial begin
        logic [7:0] c, d, t;
        logic [6:0] a;
        logic ack;
        int n;
        void'($urandom(13285));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(off_control_zero, rst_control_zero);
        rd(off_data_buffer, rst_data_buffer);
        rd(off_own_address, rst_own_address);
        // ****************************************
        // Every mode with both async settings
        // ****************************************
        for (int i = 0; i < 16; i++) begin
            c = {i[2:0], i[3], 2'($urandom), 1'b1, 1'($urandom)};
            t = 8'($urandom);
            wr(off_control_zero, c);
            wr(off_timeout_control, t);
            rd(off_control_zero, c);
            check({5'h0, active_function}, {5'h0, exp_func(c)});
            check({6'h0, pullup_en}, {6'h0, pullup_ctrl});
            rd(off_timeout_control, two_wire(c) ? t : 8'h00);
            rd(off_status_flags, two_wire(c) ? rst_status_flags : 8'h00);
        end
        wr(off_control_zero, 8'hc0);
        rd(off_data_buffer, rst_data_buffer);
        check({5'h0, active_function}, 8'h00);
        d = 8'($urandom);
        wr(off_control_zero, 8'ha2);
        wr(off_data_buffer, d);
        wr(off_control_zero, 8'hc2);
        rd(off_data_buffer, d);
        c = 8'($urandom);
        wr(off_own_address, c);
        rd(off_own_address, c);
        wr(off_status_flags, 8'hff);
        rd(off_status_flags, 8'h9b);
        wr(off_status_flags, 8'h00);
        rd(3'(5 + $urandom % 3), 8'h00);
        // ****************************************
        // Bus traffic for each debounce setting
        // ****************************************
        for (int k = 0; k < 4; k++) begin
            a = {2'b10, 5'($urandom)};
            m.half = 12 + 6 * k;
            wr(off_control_zero, {3'h6, 1'b0, 2'(k), 2'b10});
            wr(off_own_address, {a, 1'($urandom)});
            n = irq_cnt;
            m.start();
            m.send({a, 1'b0}, ack);
            check({7'h0, ack}, 8'h00);
            check(8'(irq_cnt - n), 8'h01);
            rd(off_status_flags, 8'h40, 8'h44);
            d = 8'($urandom);
            m.send(d, ack);
            check({7'h0, ack}, 8'h00);
            m.stop();
            rd(off_data_buffer, d);
            n = irq_cnt;
            m.start();
            m.send({a ^ 7'(1 + $urandom % 127), 1'b0}, ack);
            check({7'h0, ack}, 8'h01);
            check(8'(irq_cnt - n), 8'h00);
            m.stop();
            t = 8'($urandom);
            wr(off_data_buffer, t);
            wr(off_status_flags, 8'h10);
            m.start();
            m.send({a, 1'b1}, ack);
            check({7'h0, ack}, 8'h00);
            rd(off_status_flags, 8'h04, 8'h04);
            m.recv(c, 1'b1);
            check(c, t);
            m.stop();
            wr(off_status_flags, 8'h00);
            // A clock spike one cycle shorter than the filter must vanish; with no filter it adds a bit.
            m.glitch = (k >= 2) ? 3 : 1;
            m.start();
            m.send({a, 1'b0}, ack);
            check({7'h0, ack}, {7'h0, k == 0});
            m.stop();
        end
        final_report();
    end
endmodule
`default_nettype wire
